// ==== tb/ped_diag_asserts.sv ====
// Concurrent checks on the ports of the error and diagnostic event block
`timescale 1ns/1ps
module ped_diag_asserts
   import ped_pkg::*;
(
   // Clock and reset
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   // Register reads
   input wire logic [7:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   // Partner and status
   input wire logic [15:0] RX_EVENT_CODE,
   input wire logic [7:0]  RESPONSE_ERROR_ID,
   input wire logic        WIRE_BREAK,
   input wire logic        SYSTEM_FAULT_INDICATOR,
   input wire logic        DEVICE_STOPPED,
   input wire logic        DIAG_EVENT
);
   logic [7:0] ra_ff;
   logic [7:0] nxt_ra;
   logic       lvl_ff;
   logic [3:0] age_ff;
   logic [3:0] nxt_age;

   // Read address in flight; age of the raw line level, saturating so it never wraps
   always_comb
   begin
      nxt_ra  = (S_AXI_ARVALID && S_AXI_ARREADY) ? S_AXI_ARADDR : ra_ff;
      nxt_age = (WIRE_BREAK != lvl_ff) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ra_ff  <= 8'h00;
         lvl_ff <= 1'b0;
         age_ff <= 4'h0;
      end
      else
      begin
         ra_ff  <= nxt_ra;
         lvl_ff <= WIRE_BREAK;
         age_ff <= nxt_age;
      end
   end

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   // Steps of a raised event and of register reads
   sequence s_lit;
      ##[0:1] SYSTEM_FAULT_INDICATOR;
   endsequence
   sequence s_job_rd;
      S_AXI_RVALID && ra_ff == OFS_JOB;
   endsequence
   sequence s_diag_rd;
      S_AXI_RVALID && ra_ff == OFS_DIAG;
   endsequence

   a_id_0a: assert property (RX_EVENT_CODE == 16'h0905 |=> RESPONSE_ERROR_ID == RID_0A)
      else $error("identifier for 0905 wrong");
   a_id_2a_34: assert property ((RX_EVENT_CODE == 16'h090d |=> RESPONSE_ERROR_ID == RID_2A)
      and (RX_EVENT_CODE == 16'h090c |=> RESPONSE_ERROR_ID == RID_34))
      else $error("identifier for 090d or 090c wrong");
   a_id_0c: assert property (RX_EVENT_CODE inside {16'h0301, 16'h0609, 16'h060a, 16'h0902}
      |=> RESPONSE_ERROR_ID == RID_0C)
      else $error("identifier 0c missing");
   a_id_12_14: assert property ((RX_EVENT_CODE == 16'h0904 |=> RESPONSE_ERROR_ID == RID_12)
      and (RX_EVENT_CODE == 16'h0903 |=> RESPONSE_ERROR_ID == RID_14))
      else $error("identifier 12 or 14 missing");
   a_event_cause: assert property (DIAG_EVENT |-> age_ff <= 4'h8)
      else $error("event without a line change");
   a_event_pulse: assert property (DIAG_EVENT |=> !DIAG_EVENT)
      else $error("event longer than one cycle");
   a_fault_lit: assert property (DIAG_EVENT |-> s_lit)
      else $error("fault indicator not lit");
   a_stop_cause: assert property ($rose(DEVICE_STOPPED) |-> DIAG_EVENT || $past(DIAG_EVENT))
      else $error("stop without an event");
   a_status_zero: assert property (s_job_rd ##0 !S_AXI_RDATA[JOB_ERR]
      |-> S_AXI_RDATA[15:0] == 16'h0000)
      else $error("status word nonzero without error");
   a_break_bits: assert property (s_diag_rd ##0 S_AXI_RDATA[D8_LINE_BREAK] |-> S_AXI_RDATA[D8_FAULTY]
      && S_AXI_RDATA[D8_EXTERNAL] && S_AXI_RDATA[8 + D10_COMM_ERR])
      else $error("line break bits incomplete");
endmodule : ped_diag_asserts

bind ped_diag ped_diag_asserts u_ped_chk (
   .CORE_CLK, .RST_N, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
   .S_AXI_RVALID, .RX_EVENT_CODE, .RESPONSE_ERROR_ID, .WIRE_BREAK,
   .SYSTEM_FAULT_INDICATOR, .DEVICE_STOPPED, .DIAG_EVENT
);

// ==== tb/ped_diag_tb.sv ====
// Self-checking bench for the error and diagnostic event block
`timescale 1ns/1ps
module ped_diag_tb
   import ped_pkg::*;
;
   logic        CORE_CLK = 1'b0;
   logic        RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        JOB_START, JOB_END, JOB_FAULT, WIRE_BREAK, brk_req;
   logic        SYSTEM_FAULT_INDICATOR, DEVICE_STOPPED, DIAG_EVENT;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, RESPONSE_ERROR_ID;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [15:0] JOB_CAUSE, RX_EVENT_CODE, code_req, cause;
   logic [3:0]  lag;
   logic [65:0] rq[$];
   logic [65:0] e;
   logic [1:0]  bq[$];
   logic [15:0] codes [18] = '{16'h0905, 16'h0301, 16'h0609, 16'h060a, 16'h0902, 16'h0601,
      16'h0604, 16'h0904, 16'h0903, 16'h0602, 16'h0603, 16'h090a, 16'h090d, 16'h060f,
      16'h0909, 16'h090c, 16'h060e, 16'h0908};
   int          mismatches = 0, compares = 0, pulses = 0, seed = 81717, i;

   ped_diag dut (.CORE_CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB(4'hf), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
      .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .JOB_START, .JOB_END,
      .JOB_FAULT, .JOB_CAUSE, .RX_EVENT_CODE, .RESPONSE_ERROR_ID, .WIRE_BREAK,
      .SYSTEM_FAULT_INDICATOR, .DEVICE_STOPPED, .DIAG_EVENT);
   ped_partner u_far (.clk(CORE_CLK), .code_req, .lag, .brk_req,
      .rx_event_code(RX_EVENT_CODE), .wire_break(WIRE_BREAK));

   always #2.5 CORE_CLK = ~CORE_CLK;

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task close_out;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   // Expected identifier; the first matching row wins for shared codes
   function automatic logic [7:0] exp_id(input logic [15:0] c);
      case (c)
         16'h0905: exp_id = 8'h0a;
         16'h0301, 16'h0609, 16'h060a, 16'h0902: exp_id = 8'h0c;
         16'h0601, 16'h0604: exp_id = 8'h10;
         16'h0904: exp_id = 8'h12;
         16'h0903: exp_id = 8'h14;
         16'h0602, 16'h0603, 16'h090a: exp_id = 8'h16;
         16'h090d: exp_id = 8'h2a;
         16'h060f, 16'h0909: exp_id = 8'h32;
         16'h090c: exp_id = 8'h34;
         16'h060e, 16'h0908: exp_id = 8'h36;
         default: exp_id = 8'h00;
      endcase
   endfunction : exp_id

   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      int n;
      @(posedge CORE_CLK);
      bq.push_back(r);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      S_AXI_BREADY  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge CORE_CLK);
         if (S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY)
            S_AXI_WVALID <= 1'b0;
         if (S_AXI_BVALID)
         begin
            S_AXI_BREADY <= 1'b0;
            break;
         end
      end
      if (n == 40)
         close_fail();
   endtask : wr

   // Bus read; expected data is stored with its mask, which is applied to the read data on compare
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hffffffff, input logic [1:0] r = RESP_OKAY);
      int n;
      @(posedge CORE_CLK);
      rq.push_back({m, r, d});
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge CORE_CLK);
         if (S_AXI_ARREADY)
            S_AXI_ARVALID <= 1'b0;
         if (S_AXI_RVALID)
         begin
            S_AXI_RREADY <= 1'b0;
            break;
         end
      end
      if (n == 40)
         close_fail();
   endtask : rd

   task close_fail;
      mismatches++;
      close_out();
   endtask : close_fail

   task automatic job(input logic s, input logic n, input logic f, input logic [15:0] c);
      JOB_START <= s;
      JOB_END   <= n;
      JOB_FAULT <= f;
      JOB_CAUSE <= c;
      @(posedge CORE_CLK);
      JOB_START <= 1'b0;
      JOB_END   <= 1'b0;
      @(posedge CORE_CLK);
   endtask : job

   // Line change; the long settle covers the three-stage synchroniser
   task automatic brk(input logic b);
      brk_req <= b;
      repeat (12) @(posedge CORE_CLK);
   endtask : brk

   // Bus results are matched against the oldest note as they appear
   always @(posedge CORE_CLK)
   begin
      if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         e = rq.pop_front();
         check({S_AXI_RRESP, S_AXI_RDATA & e[65:34]}, e[33:0]);
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
         check({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()});
      if (DIAG_EVENT)
         pulses++;
   end

   initial
   begin
      repeat (30000) @(posedge CORE_CLK);
      close_fail();
   end

   initial
   begin
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
      {JOB_START, JOB_END, JOB_FAULT, brk_req} = 4'h0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, JOB_CAUSE, code_req, lag} = 84'h0;
      RST_N = 1'b0;
      repeat (20) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      @(posedge CORE_CLK);
      // Defaults and refused accesses
      rd(OFS_CTRL, 32'h01500000);
      rd(8'h14, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(OFS_JOB, 32'h1, RESP_SLVERR);
      rd(OFS_JOB, 32'h0, 32'h0007ffff);
      // Faulty job, restart, then a clean job started and ended in one cycle
      cause = 16'($random(seed)) | 16'h0001;
      job(1'b1, 1'b0, 1'b0, 16'h0000);
      job(1'b0, 1'b1, 1'b1, cause);
      rd(OFS_JOB, {15'h0, 1'b1, cause}, 32'h0001ffff);
      job(1'b1, 1'b0, 1'b0, 16'h0000);
      rd(OFS_JOB, 32'h0, 32'h0001ffff);
      job(1'b1, 1'b1, 1'b0, cause);
      rd(OFS_JOB, 32'h00020000, 32'h0003ffff);
      // Every identifier row, then random codes, partner prompt and slow
      for (i = 0; i < 26; i++)
      begin
         code_req <= (i < 18) ? codes[i] : {12'h090, 4'($random(seed))};
         lag      <= (i % 3 == 1) ? 4'h6 : 4'h0;
         repeat (10) @(posedge CORE_CLK);
         check({26'h0, RESPONSE_ERROR_ID}, {26'h0, exp_id(code_req)});
      end
      // Break while diagnostics are disabled raises nothing
      brk(1'b1);
      brk(1'b0);
      check(34'(pulses), 34'h0);
      rd(OFS_EVENT, 32'h0, 32'h00020000);
      // Break with handler installed, during a running job
      wr(OFS_CTRL, 32'h01500003);
      job(1'b1, 1'b0, 1'b0, 16'h0000);
      brk(1'b1);
      check(34'(pulses), 34'h1);
      check({33'h0, SYSTEM_FAULT_INDICATOR}, 34'h1);
      check({33'h0, DEVICE_STOPPED}, 34'h0);
      rd(OFS_DIAG, 32'h01500225);
      rd(OFS_JOB, 32'h00040000, 32'h00070000);
      job(1'b0, 1'b1, 1'b0, 16'h0000);
      rd(OFS_JOB, 32'h00020000, 32'h00070000);
      brk(1'b0);
      check(34'(pulses), 34'h2);
      rd(OFS_DIAG, 32'h1, 32'h1);
      rd(OFS_EVENT, 32'h0002080d, 32'h0007ffff);
      rd(OFS_EVENT, 32'h0003080d, 32'h0007ffff);
      rd(OFS_DIAG, 32'h0, 32'h1);
      check({33'h0, SYSTEM_FAULT_INDICATOR}, 34'h0);
      // No handler: the device stops until told to run again
      wr(OFS_CTRL, 32'h01500001);
      brk(1'b1);
      check({33'h0, DEVICE_STOPPED}, 34'h1);
      rd(OFS_CTRL, 32'h4, 32'h4);
      wr(OFS_CTRL, 32'h01500005);
      repeat (2) @(posedge CORE_CLK);
      check({33'h0, DEVICE_STOPPED}, 34'h0);
      brk(1'b0);
      check(34'(pulses), 34'h4);
      close_out();
   end
endmodule : ped_diag_tb

// ==== tb/ped_partner.sv ====
// Behavioural model of the serial partner: frame event codes and line state
`timescale 1ns/1ps
module ped_partner
(
   // Clock and commands from the bench
   input wire logic        clk,
   input wire logic [15:0] code_req,
   input wire logic [3:0]  lag,
   input wire logic        brk_req,
   // Line side
   output logic [15:0]     rx_event_code,
   output logic            wire_break
);
   logic [3:0] cnt;

   initial
   begin
      rx_event_code = 16'h0000;
      wire_break    = 1'b0;
      cnt           = 4'h0;
   end

   // A slow partner reports its frame fault only after the chosen lag
   always @(posedge clk)
   begin
      if (code_req != rx_event_code && cnt < lag)
         cnt <= cnt + 4'h1;
      else
      begin
         rx_event_code <= code_req;
         cnt           <= 4'h0;
      end
   end

   // A real break is not aligned to the core clock
   always @(brk_req) #1.7 wire_break = brk_req;
endmodule : ped_partner

// ==== verilog/ped_diag.sv ====
// Error reporting and diagnostic event logic of the point-to-point interface
//
// What this block does
// - A job ending in fault raises the job error flag and loads the cause code.
// - The status word reads zero unless the job error flag is set.
// - An error in a received send or fetch frame is answered with an identifier in byte four.
// - Identifier 0a maps to 0905, 2a to 090d and 34 to 090c.
// - Identifier 0c maps to 0301, 0609, 060a, 0902; 12 to 0904; 14 to 0903.
// - A wire break on the serial line raises a diagnostic event with code 080d.
// - Diagnostic events are raised only while diagnostic interrupts are enabled.
// - Every diagnostic condition is reported as incoming and again as outgoing.
// - A diagnostic event never disturbs a send or receive job in progress.
// - With no diagnostic handler installed, an event puts the device into stop.
// - A diagnostic event lights the system fault indicator.
// - Diagnostic bytes six and seven carry the address of the raising module.
// - Byte 8 bit 0 flags a faulty module while any error remains queued.
// - The faulty module bit clears only after all queued errors went outgoing.
// - A line break sets faulty, line break, external and communication bits at once.
`timescale 1ns/1ps
module ped_diag
   import ped_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   // AXI4-Lite write address
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Job engine side
   input  wire logic        JOB_START,
   input  wire logic        JOB_END,
   input  wire logic        JOB_FAULT,
   input  wire logic [15:0] JOB_CAUSE,
   // Partner event to response identifier
   input  wire logic [15:0] RX_EVENT_CODE,
   output logic [7:0]       RESPONSE_ERROR_ID,
   // Serial line wire-break detector, asynchronous
   input  wire logic        WIRE_BREAK,
   // Device status
   output logic             SYSTEM_FAULT_INDICATOR,
   output logic             DEVICE_STOPPED,
   output logic             DIAG_EVENT
);

   // Event code to response identifier lookup
   function automatic logic [7:0] map_id(input logic [15:0] ev);
      logic [7:0] id;
      id = RID_NONE;
      case (ev)
         16'h0905:                            id = RID_0A;
         16'h0301, 16'h0609, 16'h060a,
         16'h0902:                            id = RID_0C;
         16'h0601, 16'h0604:                  id = RID_10;
         16'h0904:                            id = RID_12;
         16'h0903:                            id = RID_14;
         16'h0602, 16'h0603, 16'h090a:        id = RID_16;
         16'h090d:                            id = RID_2A;
         16'h060f, 16'h0909:                  id = RID_32;
         16'h090c:                            id = RID_34;
         16'h060e, 16'h0908:                  id = RID_36;
         default:                             id = RID_NONE;
      endcase
      return id;
   endfunction : map_id

   // Pin synchroniser, three stages, and the debounced break level
   logic [2:0]  sync_ff, nxt_sync;
   logic        brk_ff, nxt_brk;
   // Registers
   logic [31:0] ctrl_ff, nxt_ctrl;
   ped_job_t    job_ff, nxt_job;
   logic        done_ff, nxt_done;
   logic        busy_ff, nxt_busy;
   ped_diag_t   diag_ff, nxt_diag;
   logic        ev_valid_ff, nxt_ev_valid;
   logic        ev_out_ff, nxt_ev_out;
   logic        ev_lost_ff, nxt_ev_lost;
   logic        pend_ff, nxt_pend;
   logic        pend_out_ff, nxt_pend_out;
   logic        sf_ff, nxt_sf;
   logic        pulse_ff, nxt_pulse;
   ped_op_t     op_ff, nxt_op;
   logic [7:0]  rid_ff, nxt_rid;
   // Bus state
   logic        aw_ff, nxt_aw, w_ff, nxt_w;
   logic [7:0]  awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0]  wstrb_ff, nxt_wstrb;
   logic        bvalid_ff, nxt_bvalid;
   logic [1:0]  bresp_ff, nxt_bresp;
   logic        rvalid_ff, nxt_rvalid;
   logic [1:0]  rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        wr_go, rd_go, ev_rd, brk_chg, raise;
   // Write strobe merge, byte lanes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction : merge

   // Handshake and device outputs
   assign S_AXI_AWREADY = !aw_ff && !bvalid_ff;
   assign S_AXI_WREADY  = !w_ff && !bvalid_ff;
   assign S_AXI_ARREADY = !rvalid_ff;
   assign S_AXI_BVALID  = bvalid_ff;
   assign S_AXI_BRESP   = bresp_ff;
   assign S_AXI_RVALID  = rvalid_ff;
   assign S_AXI_RRESP   = rresp_ff;
   assign S_AXI_RDATA   = rdata_ff;
   assign RESPONSE_ERROR_ID      = rid_ff;
   assign SYSTEM_FAULT_INDICATOR = sf_ff;
   assign DEVICE_STOPPED         = (op_ff == OP_STOP);
   assign DIAG_EVENT             = pulse_ff;
   assign wr_go   = aw_ff && w_ff && !bvalid_ff;
   assign rd_go   = S_AXI_ARVALID && !rvalid_ff;
   assign ev_rd   = rd_go && (S_AXI_ARADDR == OFS_EVENT);
   // A change counts once stages two and three agree
   assign brk_chg = (sync_ff[1] == sync_ff[2]) && (sync_ff[2] != brk_ff);
   assign raise   = brk_chg && ctrl_ff[CTRL_DIAG_EN];

   // Synchroniser and debounced break level
   always_comb
   begin
      nxt_sync = {sync_ff[1:0], WIRE_BREAK};
      nxt_brk  = brk_chg ? sync_ff[2] : brk_ff;
   end

   // Job result tracking; runs apart from diagnostics so jobs are never disturbed
   always_comb
   begin
      nxt_job  = job_ff;
      nxt_done = done_ff;
      nxt_busy = busy_ff;
      nxt_rid  = map_id(RX_EVENT_CODE);
      if (JOB_START)
      begin
         nxt_job  = '0;
         nxt_done = 1'b0;
         nxt_busy = 1'b1;
      end
      if (JOB_END && (busy_ff || JOB_START))
      begin
         nxt_busy = 1'b0;
         nxt_done = 1'b1;
         nxt_job.err    = JOB_FAULT;
         nxt_job.status = JOB_FAULT ? JOB_CAUSE : '0;
      end
   end

   // Diagnostic event state; software clears come before the sets so a set wins
   always_comb
   begin
      nxt_diag     = diag_ff;
      nxt_ev_valid = ev_valid_ff;
      nxt_ev_out   = ev_out_ff;
      nxt_ev_lost  = ev_lost_ff;
      nxt_pend     = pend_ff;
      nxt_pend_out = pend_out_ff;
      nxt_sf       = sf_ff;
      nxt_op       = op_ff;
      nxt_pulse    = 1'b0;
      nxt_diag.addr = ctrl_ff[CTRL_ADDR_LSB +: 16];
      // Reading the event log consumes the oldest entry
      if (ev_rd && ev_valid_ff)
      begin
         nxt_ev_valid = pend_ff;
         nxt_ev_out   = pend_out_ff;
         nxt_pend     = 1'b0;
      end
      if (wr_go && awaddr_ff == OFS_DIAG && wstrb_ff[0] && wdata_ff[0])
      begin
         nxt_ev_lost = 1'b0;
         nxt_diag.byte10[D10_IRQ_LOSS] = 1'b0;
      end
      if (wr_go && awaddr_ff == OFS_CTRL && wstrb_ff[0] && wdata_ff[CTRL_RUN])
         nxt_op = OP_RUN;
      if (raise)
      begin
         nxt_pulse = 1'b1;
         nxt_sf    = 1'b1;
         if (!ctrl_ff[CTRL_HANDLER])
            nxt_op = OP_STOP;
         // Queue as incoming or outgoing; a third unread event is lost
         if (!nxt_ev_valid)
         begin
            nxt_ev_valid = 1'b1;
            nxt_ev_out   = !sync_ff[2];
         end
         else if (!nxt_pend)
         begin
            nxt_pend     = 1'b1;
            nxt_pend_out = !sync_ff[2];
         end
         else
         begin
            nxt_ev_lost = 1'b1;
            nxt_diag.byte10[D10_IRQ_LOSS] = 1'b1;
         end
         if (sync_ff[2])
         begin
            nxt_diag.byte8[D8_FAULTY]     = 1'b1;
            nxt_diag.byte8[D8_LINE_BREAK] = 1'b1;
            nxt_diag.byte8[D8_EXTERNAL]   = 1'b1;
            nxt_diag.byte10[D10_COMM_ERR] = 1'b1;
         end
         else
         begin
            nxt_diag.byte8[D8_LINE_BREAK] = 1'b0;
            nxt_diag.byte8[D8_EXTERNAL]   = 1'b0;
            nxt_diag.byte10[D10_COMM_ERR] = 1'b0;
         end
      end
      // Faulty stays while anything is queued; clears once all went outgoing
      if (diag_ff.byte8[D8_FAULTY] && !sync_ff[2] && !brk_ff && !nxt_ev_valid)
      begin
         nxt_diag.byte8[D8_FAULTY] = 1'b0;
         nxt_sf = 1'b0;
      end
   end

   // AXI4-Lite slave
   always_comb
   begin
      nxt_aw     = aw_ff;
      nxt_w      = w_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata  = wdata_ff;
      nxt_wstrb  = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp  = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp  = rresp_ff;
      nxt_rdata  = rdata_ff;
      nxt_ctrl   = ctrl_ff;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         nxt_aw     = 1'b1;
         nxt_awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         nxt_w     = 1'b1;
         nxt_wdata = S_AXI_WDATA;
         nxt_wstrb = S_AXI_WSTRB;
      end
      if (wr_go)
      begin
         nxt_aw     = 1'b0;
         nxt_w      = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp  = RESP_OKAY;
         case (awaddr_ff)
            OFS_CTRL: nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff) & ~(32'h1 << CTRL_RUN);
            OFS_DIAG: nxt_bresp = RESP_OKAY;
            default:  nxt_bresp = RESP_SLVERR;
         endcase
      end
      if (bvalid_ff && S_AXI_BREADY)
         nxt_bvalid = 1'b0;
      if (rd_go)
      begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = RESP_OKAY;
         case (S_AXI_ARADDR)
            OFS_CTRL:  nxt_rdata = ctrl_ff | {31'h0, op_ff == OP_STOP} << CTRL_RUN;
            OFS_JOB:   nxt_rdata = {13'h0, busy_ff, done_ff, job_ff.err, job_ff.status};
            OFS_DIAG:  nxt_rdata = {diag_ff.addr, diag_ff.byte10, diag_ff.byte8};
            OFS_EVENT: nxt_rdata = {13'h0, ev_lost_ff, ev_valid_ff, ev_out_ff, EVT_WIRE_BREAK};
            OFS_RESP:  nxt_rdata = {24'h0, rid_ff};
            default:
            begin
               nxt_rdata = '0;
               nxt_rresp = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_ff && S_AXI_RREADY)
         nxt_rvalid = 1'b0;
   end

   // Register all state
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync_ff     <= '0;
         brk_ff      <= 1'b0;
         ctrl_ff     <= {MDL_ADDR_RST, 16'h0};
         job_ff      <= '0;
         done_ff     <= 1'b0;
         busy_ff     <= 1'b0;
         diag_ff     <= '0;
         ev_valid_ff <= 1'b0;
         ev_out_ff   <= 1'b0;
         ev_lost_ff  <= 1'b0;
         pend_ff     <= 1'b0;
         pend_out_ff <= 1'b0;
         sf_ff       <= 1'b0;
         pulse_ff    <= 1'b0;
         op_ff       <= OP_RUN;
         rid_ff      <= RID_NONE;
         aw_ff       <= 1'b0;
         w_ff        <= 1'b0;
         awaddr_ff   <= '0;
         wdata_ff    <= '0;
         wstrb_ff    <= '0;
         bvalid_ff   <= 1'b0;
         bresp_ff    <= RESP_OKAY;
         rvalid_ff   <= 1'b0;
         rresp_ff    <= RESP_OKAY;
         rdata_ff    <= '0;
      end
      else
      begin
         sync_ff     <= nxt_sync;
         brk_ff      <= nxt_brk;
         ctrl_ff     <= nxt_ctrl;
         job_ff      <= nxt_job;
         done_ff     <= nxt_done;
         busy_ff     <= nxt_busy;
         diag_ff     <= nxt_diag;
         ev_valid_ff <= nxt_ev_valid;
         ev_out_ff   <= nxt_ev_out;
         ev_lost_ff  <= nxt_ev_lost;
         pend_ff     <= nxt_pend;
         pend_out_ff <= nxt_pend_out;
         sf_ff       <= nxt_sf;
         pulse_ff    <= nxt_pulse;
         op_ff       <= nxt_op;
         rid_ff      <= nxt_rid;
         aw_ff       <= nxt_aw;
         w_ff        <= nxt_w;
         awaddr_ff   <= nxt_awaddr;
         wdata_ff    <= nxt_wdata;
         wstrb_ff    <= nxt_wstrb;
         bvalid_ff   <= nxt_bvalid;
         bresp_ff    <= nxt_bresp;
         rvalid_ff   <= nxt_rvalid;
         rresp_ff    <= nxt_rresp;
         rdata_ff    <= nxt_rdata;
      end
   end

endmodule : ped_diag

// ==== verilog/ped_pkg.sv ====
// Package for the point-to-point error and diagnostic event block
package ped_pkg;

   // AXI4-Lite register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_JOB      = 8'h04;
   localparam logic [7:0] OFS_DIAG     = 8'h08;
   localparam logic [7:0] OFS_EVENT    = 8'h0c;
   localparam logic [7:0] OFS_RESP     = 8'h10;

   // Control register fields
   localparam int CTRL_DIAG_EN   = 0;
   localparam int CTRL_HANDLER   = 1;
   localparam int CTRL_RUN       = 2;
   localparam int CTRL_ADDR_LSB  = 16;

   // Job register fields
   localparam int JOB_ERR        = 16;
   localparam int JOB_DONE       = 17;
   localparam int JOB_BUSY       = 18;

   // Diagnostic byte 8 and byte 10 bit positions
   localparam int D8_FAULTY      = 0;
   localparam int D8_EXTERNAL    = 2;
   localparam int D8_LINE_BREAK  = 5;
   localparam int D10_COMM_ERR   = 1;
   localparam int D10_IRQ_LOSS   = 6;

   // Event log fields
   localparam int EV_OUTGOING    = 16;
   localparam int EV_VALID       = 17;
   localparam int EV_LOST        = 18;

   // Event code of the wire-break diagnostic
   localparam logic [15:0] EVT_WIRE_BREAK = 16'h080d;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Response error identifiers
   localparam logic [7:0] RID_NONE = 8'h00;
   localparam logic [7:0] RID_0A   = 8'h0a;
   localparam logic [7:0] RID_0C   = 8'h0c;
   localparam logic [7:0] RID_10   = 8'h10;
   localparam logic [7:0] RID_12   = 8'h12;
   localparam logic [7:0] RID_14   = 8'h14;
   localparam logic [7:0] RID_16   = 8'h16;
   localparam logic [7:0] RID_2A   = 8'h2a;
   localparam logic [7:0] RID_32   = 8'h32;
   localparam logic [7:0] RID_34   = 8'h34;
   localparam logic [7:0] RID_36   = 8'h36;

   // Default module address of this interface
   localparam logic [15:0] MDL_ADDR_RST = 16'h0150;

   // Operating state of the device
   typedef enum logic [0:0] {OP_RUN, OP_STOP} ped_op_t;

   // Diagnostic data as presented to the handler
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  byte8;
      logic [7:0]  byte10;
   } ped_diag_t;

   // Job result
   typedef struct packed {
      logic        err;
      logic [15:0] status;
   } ped_job_t;

endpackage : ped_pkg
